// [hw/aec_defs.svh]
// Constants for the alignment exception check
`ifndef AEC_DEFS_SVH
`define AEC_DEFS_SVH
`define AEC_MSR_DATA_RELOCATE 27
`define AEC_CACHE_IGNORE_BITS 5
`define AEC_STRING_MAX_LEN    8'h80
`define AEC_MISALIGN_EXTRA    2'h1
`define AEC_CROSS_EXTRA       2'h2
`endif

// [hw/aec_pkg.sv]
// Types for the alignment exception check
package aec_pkg;
    typedef enum logic [3:0] {
        AEC_OP_INT_LOAD  = 4'h0,
        AEC_OP_INT_STORE = 4'h1,
        AEC_OP_STRING    = 4'h2,
        AEC_OP_CACHE_CTL = 4'h3,
        AEC_OP_ZERO_BLK  = 4'h4,
        AEC_OP_CACHE_RD  = 4'h5,
        AEC_OP_LOAD_RSV  = 4'h6,
        AEC_OP_STORE_CND = 4'h7,
        AEC_OP_AUX_LOAD  = 4'h8,
        AEC_OP_AUX_STORE = 4'h9,
        AEC_OP_IFETCH    = 4'hA
    } aec_op_t;
    typedef enum logic [1:0] {
        AEC_SZ_BYTE  = 2'h0,
        AEC_SZ_HALF  = 2'h1,
        AEC_SZ_WORD  = 2'h2,
        AEC_SZ_DOUBLE = 2'h3
    } aec_size_t;
    typedef struct packed {
        aec_op_t    op;
        aec_size_t  size;
        logic [7:0] str_len;
        logic [31:0] ea;
        logic       cachable;
        logic       write_through;
        logic       little_endian;
    } aec_req_t;
    typedef struct packed {
        logic       fault;
        logic       misaligned;
        logic       crosses_word;
    } aec_chk_t;
endpackage : aec_pkg

// [hw/aec_decide.sv]
// Combinational alignment decision for one request
`timescale 1ns/1ps
`default_nettype none
`include "aec_defs.svh"
module aec_decide (
    input  wire aec_pkg::aec_req_t req,
    input  wire logic              data_relocate_enable,
    output aec_pkg::aec_chk_t      chk
);
    logic [1:0] low;
    logic [2:0] span;
    logic [3:0] end_ofs;
    // Misalignment and fault classification
    always_comb begin
        low = req.ea[1:0];
        chk = '0;
        case (req.size)
            aec_pkg::AEC_SZ_HALF:   span = 3'h2;
            aec_pkg::AEC_SZ_WORD:   span = 3'h4;
            aec_pkg::AEC_SZ_DOUBLE: span = 3'h4;
            default:                span = 3'h1;
        endcase
        // Halfword by two, word by four, byte always aligned
        case (req.size)
            aec_pkg::AEC_SZ_HALF:   chk.misaligned = low[0];
            aec_pkg::AEC_SZ_WORD:   chk.misaligned = |low;
            aec_pkg::AEC_SZ_DOUBLE: chk.misaligned = |low;
            default:                chk.misaligned = 1'b0;
        endcase
        // Lowest byte address plus span tells a word crossing
        end_ofs = {2'h0, low} + {1'h0, span} - 4'h1;
        chk.crosses_word = end_ofs[2];
        case (req.op)
            aec_pkg::AEC_OP_ZERO_BLK:
                chk.fault = !data_relocate_enable && (!req.cachable || req.write_through);
            aec_pkg::AEC_OP_CACHE_CTL:
                chk.fault = 1'b0;
            aec_pkg::AEC_OP_CACHE_RD, aec_pkg::AEC_OP_LOAD_RSV, aec_pkg::AEC_OP_STORE_CND:
                chk.fault = |low;
            aec_pkg::AEC_OP_AUX_LOAD, aec_pkg::AEC_OP_AUX_STORE: begin
                if (req.size == aec_pkg::AEC_SZ_HALF)
                    chk.fault = low[0];
                else if (req.size == aec_pkg::AEC_SZ_BYTE)
                    chk.fault = 1'b0;
                else
                    chk.fault = |low;
            end
            aec_pkg::AEC_OP_IFETCH:
                chk.fault = |low;
            aec_pkg::AEC_OP_STRING:
                chk.fault = (req.str_len == 8'h00) || (req.str_len > `AEC_STRING_MAX_LEN);
            default:
                chk.fault = 1'b0;
        endcase
        // Cache control ops never report misalignment
        if (req.op == aec_pkg::AEC_OP_CACHE_CTL || req.op == aec_pkg::AEC_OP_ZERO_BLK) begin
            chk.misaligned = 1'b0;
            chk.crosses_word = 1'b0;
        end
        // little_endian is deliberately unused here
    end
endmodule : aec_decide
`default_nettype wire

// [hw/aec_alignment_check.sv]
// Alignment exception check for the load/store pipeline
`timescale 1ns/1ps
`default_nettype none
`include "aec_defs.svh"
module aec_alignment_check (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              req_valid,
    input  wire aec_pkg::aec_req_t req,
    input  wire logic [31:0]       machine_state,
    output logic                   req_ready,
    output logic                   exc_valid,
    output logic [31:0]            exc_addr,
    output logic                   acc_valid,
    output aec_pkg::aec_req_t      acc_req,
    output logic [1:0]             acc_extra_cycles,
    output logic                   acc_last
);
    typedef enum logic [1:0] {
        AEC_ST_IDLE  = 2'b01,
        AEC_ST_EXTRA = 2'b10
    } aec_state_t;

    aec_state_t        state;
    aec_state_t        next_state;
    logic [1:0]        wait_cnt;
    logic [1:0]        next_wait_cnt;
    logic              next_req_ready;
    logic              next_exc_valid;
    logic [31:0]       next_exc_addr;
    logic              next_acc_valid;
    aec_pkg::aec_req_t next_acc_req;
    logic [1:0]        next_acc_extra_cycles;
    logic              next_acc_last;
    aec_pkg::aec_chk_t chk;
    logic              data_relocate_enable;
    logic              take;

    // Relocate bit, numbered from the most significant end
    assign data_relocate_enable = machine_state[31 - `AEC_MSR_DATA_RELOCATE];
    assign take = req_valid && req_ready;

    aec_decide u_decide (
        .req                  (req),
        .data_relocate_enable (data_relocate_enable),
        .chk                  (chk)
    );

    // Issue control: fault, plain access, or access with extra cycles
    always_comb begin
        next_state            = state;
        next_wait_cnt         = wait_cnt;
        next_req_ready        = req_ready;
        next_exc_valid        = 1'b0;
        next_exc_addr         = exc_addr;
        next_acc_valid        = 1'b0;
        next_acc_req          = acc_req;
        next_acc_extra_cycles = acc_extra_cycles;
        next_acc_last         = 1'b0;
        case (state)
            AEC_ST_IDLE: begin
                if (take) begin
                    next_exc_addr = req.ea;
                    if (chk.fault) begin
                        next_exc_valid = 1'b1;
                    end else begin
                        next_acc_valid = 1'b1;
                        next_acc_req   = req;
                        if (chk.misaligned) begin
                            next_acc_extra_cycles = chk.crosses_word ? `AEC_CROSS_EXTRA : `AEC_MISALIGN_EXTRA;
                            next_wait_cnt  = chk.crosses_word ? `AEC_CROSS_EXTRA : `AEC_MISALIGN_EXTRA;
                            next_req_ready = 1'b0;
                            next_state     = AEC_ST_EXTRA;
                        end else begin
                            next_acc_extra_cycles = 2'h0;
                            next_acc_last         = 1'b1;
                        end
                    end
                end
            end
            AEC_ST_EXTRA: begin
                next_wait_cnt = wait_cnt - 2'h1;
                if (wait_cnt == 2'h1) begin
                    next_acc_last  = 1'b1;
                    next_req_ready = 1'b1;
                    next_state     = AEC_ST_IDLE;
                end
            end
            default: begin
                next_state     = AEC_ST_IDLE;
                next_req_ready = 1'b1;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state            <= AEC_ST_IDLE;
            wait_cnt         <= 2'h0;
            req_ready        <= 1'b1;
            exc_valid        <= 1'b0;
            exc_addr         <= 32'h0000_0000;
            acc_valid        <= 1'b0;
            acc_req          <= '0;
            acc_extra_cycles <= 2'h0;
            acc_last         <= 1'b0;
        end else begin
            state            <= next_state;
            wait_cnt         <= next_wait_cnt;
            req_ready        <= next_req_ready;
            exc_valid        <= next_exc_valid;
            exc_addr         <= next_exc_addr;
            acc_valid        <= next_acc_valid;
            acc_req          <= next_acc_req;
            acc_extra_cycles <= next_acc_extra_cycles;
            acc_last         <= next_acc_last;
        end
    end

    // Checks on the decision and the issue sequence
    sequence s_taken_misaligned;
        take && !chk.fault && chk.misaligned && !chk.crosses_word;
    endsequence
    sequence s_extra_done;
        !acc_last ##1 acc_last && req_ready;
    endsequence

    a_zero_block_fault: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_ZERO_BLK && !data_relocate_enable && !req.cachable |=> exc_valid)
        else $error("zero block to uncached region did not fault");
    a_cache_ctl_free: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_CACHE_CTL |=> !exc_valid && acc_valid && acc_last)
        else $error("cache control op faulted or stalled");
    a_reserve_word: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_LOAD_RSV && req.ea[1:0] != 2'h0 |=> exc_valid && !acc_valid)
        else $error("misaligned reserved load did not fault");
    a_aux_half: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_AUX_LOAD && req.size == aec_pkg::AEC_SZ_HALF
        |=> exc_valid == $past(req.ea[0]))
        else $error("auxiliary halfword fault wrong");
    a_aux_double: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_AUX_STORE && req.size == aec_pkg::AEC_SZ_DOUBLE && req.ea[1:0] == 2'h0
        |=> !exc_valid && acc_valid)
        else $error("word aligned auxiliary doubleword faulted");
    a_int_extra: assert property (@(posedge clock) disable iff (!resetn)
        s_taken_misaligned |=> acc_valid && !exc_valid ##0 s_extra_done)
        else $error("misaligned integer access not completed with extra cycle");
    a_byte_aligned: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_INT_LOAD && req.size == aec_pkg::AEC_SZ_BYTE |=> acc_last)
        else $error("byte access treated as misaligned");
    a_fault_no_access: assert property (@(posedge clock) disable iff (!resetn)
        exc_valid |-> !acc_valid && req_ready)
        else $error("faulting access was issued");
    a_ifetch_word: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_IFETCH |=> exc_valid == ($past(req.ea[1:0]) != 2'h0))
        else $error("instruction fetch alignment wrong");
    a_ready_returns: assert property (@(posedge clock) disable iff (!resetn)
        $fell(req_ready) |-> ##[1:3] req_ready)
        else $error("ready did not return after extra cycles");

    // Cycles spent stalled, so the stall length can be bounded
    logic [2:0]        stall_cnt;
    logic [2:0]        next_stall_cnt;

    // Count up while ready is low, clear once it returns
    always_comb begin
        next_stall_cnt = 3'h0;
        if (!req_ready)
            next_stall_cnt = stall_cnt + 3'h1;
    end

    // Stall counter register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            stall_cnt <= 3'h0;
        else
            stall_cnt <= next_stall_cnt;
    end

    // Same request with the endian attribute inverted, decided in parallel
    aec_pkg::aec_req_t req_flip;
    aec_pkg::aec_chk_t chk_flip;

    // Invert only the endian attribute
    always_comb begin
        req_flip               = req;
        req_flip.little_endian = !req.little_endian;
    end

    // Shadow decision, read only by the endian check
    aec_decide u_decide_flip (
        .req                  (req_flip),
        .data_relocate_enable (data_relocate_enable),
        .chk                  (chk_flip)
    );

    // Steps of a word-crossing access
    sequence s_taken_crossing;
        take && !chk.fault && chk.misaligned && chk.crosses_word;
    endsequence
    sequence s_cross_done;
        !acc_last && !req_ready ##1 !acc_last && !req_ready ##1 acc_last && req_ready;
    endsequence

    // Zero block that may not fault is issued as a plain access
    a_zero_block_ok: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_ZERO_BLK && (data_relocate_enable || (req.cachable && !req.write_through))
        |=> !exc_valid && acc_valid && acc_last)
        else $error("zero block faulted without cause");

    // Zero block to a write-through region with translation off always faults
    a_zero_block_wt: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_ZERO_BLK && !data_relocate_enable && req.write_through |=> exc_valid)
        else $error("zero block to write-through region did not fault");

    // Low address bits never matter to cache control
    a_cache_ctl_low: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_CACHE_CTL && req.ea[4:0] != 5'h00
        |=> acc_valid && acc_extra_cycles == 2'h0)
        else $error("cache control op used low address bits");

    // Cache read needs a word address
    a_cache_rd_word: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_CACHE_RD |=> exc_valid == ($past(req.ea[1:0]) != 2'h0))
        else $error("cache read alignment fault wrong");

    // Conditional store needs a word address
    a_store_cnd_word: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_STORE_CND |=> exc_valid == ($past(req.ea[1:0]) != 2'h0))
        else $error("conditional store alignment fault wrong");

    // Word aligned reserved load completes at once
    a_reserve_ok: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_LOAD_RSV && req.ea[1:0] == 2'h0 |=> acc_valid && acc_last)
        else $error("aligned reserved load not issued");

    // Auxiliary halfword store needs an even address
    a_aux_st_half: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_AUX_STORE && req.size == aec_pkg::AEC_SZ_HALF
        |=> exc_valid == $past(req.ea[0]))
        else $error("auxiliary halfword store fault wrong");

    // Auxiliary word off a word boundary faults
    a_aux_word: assert property (@(posedge clock) disable iff (!resetn)
        take && (req.op == aec_pkg::AEC_OP_AUX_LOAD || req.op == aec_pkg::AEC_OP_AUX_STORE)
        && req.size == aec_pkg::AEC_SZ_WORD && req.ea[1:0] != 2'h0 |=> exc_valid && !acc_valid)
        else $error("misaligned auxiliary word did not fault");

    // Auxiliary doubleword off a word boundary faults
    a_aux_dbl_bad: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_AUX_LOAD && req.size == aec_pkg::AEC_SZ_DOUBLE && req.ea[1:0] != 2'h0
        |=> exc_valid)
        else $error("misaligned auxiliary doubleword did not fault");

    // Auxiliary accesses that pass never stall
    a_aux_no_stall: assert property (@(posedge clock) disable iff (!resetn)
        take && (req.op == aec_pkg::AEC_OP_AUX_LOAD || req.op == aec_pkg::AEC_OP_AUX_STORE) && !chk.fault
        |=> acc_last && req_ready)
        else $error("auxiliary access stalled");

    // Integer accesses never fault
    a_int_no_fault: assert property (@(posedge clock) disable iff (!resetn)
        take && (req.op == aec_pkg::AEC_OP_INT_LOAD || req.op == aec_pkg::AEC_OP_INT_STORE)
        |=> acc_valid && !exc_valid)
        else $error("integer access faulted");

    // Crossing a word costs two extra cycles
    a_int_cross: assert property (@(posedge clock) disable iff (!resetn)
        s_taken_crossing |=> acc_valid && acc_extra_cycles == `AEC_CROSS_EXTRA ##0 s_cross_done)
        else $error("word crossing access sequence wrong");

    // Misaligned within a word costs one extra cycle
    a_in_word_cost: assert property (@(posedge clock) disable iff (!resetn)
        s_taken_misaligned |=> acc_extra_cycles == `AEC_MISALIGN_EXTRA)
        else $error("in-word misalignment cost wrong");

    // No stall outlasts the longest penalty
    a_stall_bound: assert property (@(posedge clock) disable iff (!resetn)
        stall_cnt <= 3'h2)
        else $error("stall lasted too long");

    // Ready returns only when the access finishes
    a_ready_rise: assert property (@(posedge clock) disable iff (!resetn)
        $rose(req_ready) |-> acc_last)
        else $error("ready returned without finishing access");

    // Word access penalised exactly when not divisible by four
    a_word_penalty: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_INT_LOAD && req.size == aec_pkg::AEC_SZ_WORD
        |=> (acc_extra_cycles != 2'h0) == ($past(req.ea[1:0]) != 2'h0))
        else $error("word misalignment classification wrong");

    // Halfword access penalised exactly on odd addresses
    a_half_penalty: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_INT_STORE && req.size == aec_pkg::AEC_SZ_HALF
        |=> (acc_extra_cycles != 2'h0) == $past(req.ea[0]))
        else $error("halfword misalignment classification wrong");

    // Bytes are never penalised
    a_byte_free: assert property (@(posedge clock) disable iff (!resetn)
        take && (req.op == aec_pkg::AEC_OP_INT_LOAD || req.op == aec_pkg::AEC_OP_INT_STORE)
        && req.size == aec_pkg::AEC_SZ_BYTE |=> acc_extra_cycles == 2'h0)
        else $error("byte access penalised");

    // Endian attribute leaves the decision unchanged
    a_endian_same: assert property (@(posedge clock) disable iff (!resetn)
        req_valid |-> chk_flip == chk)
        else $error("endian attribute changed the decision");

    // String length outside one to the maximum faults
    a_string_len: assert property (@(posedge clock) disable iff (!resetn)
        take && req.op == aec_pkg::AEC_OP_STRING
        |=> exc_valid == ($past(req.str_len) == 8'h00 || $past(req.str_len) > `AEC_STRING_MAX_LEN))
        else $error("string length fault wrong");

    // Reported address is the request's lowest byte address
    a_exc_addr: assert property (@(posedge clock) disable iff (!resetn)
        take |=> exc_addr == $past(req.ea))
        else $error("reported address wrong");

    // Issued access is the request as taken
    a_acc_copy: assert property (@(posedge clock) disable iff (!resetn)
        take && !chk.fault |=> acc_req == $past(req))
        else $error("issued access differs from request");

    // Nothing is issued or reported without a taken request
    a_only_on_take: assert property (@(posedge clock) disable iff (!resetn)
        !take |=> !exc_valid && !acc_valid)
        else $error("output pulse without a request");
endmodule : aec_alignment_check
`default_nettype wire

// [test/aec_pipe_model.sv]
// Pipeline model that presents one request and holds it until it is taken
`timescale 1ns/1ps
`default_nettype none
module aec_pipe_model (
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              load,
    input  wire aec_pkg::aec_req_t next_req,
    input  wire logic              req_ready,
    output logic                   req_valid,
    output aec_pkg::aec_req_t      req
);
    // Hold the request until a clock edge sees ready high, then scramble the released lines
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            req_valid <= 1'b0;
            req       <= '0;
        end else if (load) begin
            req_valid <= 1'b1;
            req       <= next_req;
        end else if (req_valid && req_ready) begin
            req_valid <= 1'b0;
            req       <= ~req;
        end
    end
endmodule : aec_pipe_model
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the alignment exception check
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic              clock = 1'b0;
    logic              resetn = 1'b0;
    logic              load = 1'b0;
    aec_pkg::aec_req_t next_req = '0;
    aec_pkg::aec_req_t req;
    logic              req_valid;
    logic [31:0]       machine_state = 32'h0;
    logic              req_ready, exc_valid, acc_valid, acc_last;
    logic [31:0]       exc_addr;
    aec_pkg::aec_req_t acc_req;
    logic [1:0]        acc_extra_cycles;
    int                err_total = 0;
    int                num_checks = 0;

    // Core clock, 50 ns period
    always #25 clock = ~clock;

    aec_pipe_model pipe_i (.clock(clock), .resetn(resetn), .load(load), .next_req(next_req),
        .req_ready(req_ready), .req_valid(req_valid), .req(req));
    aec_alignment_check aec_alignment_check_i (.clock(clock), .resetn(resetn), .req_valid(req_valid),
        .req(req), .machine_state(machine_state), .req_ready(req_ready), .exc_valid(exc_valid),
        .exc_addr(exc_addr), .acc_valid(acc_valid), .acc_req(acc_req),
        .acc_extra_cycles(acc_extra_cycles), .acc_last(acc_last));

    // Expected fault from operation, address, attributes and relocate bit
    function automatic logic exp_fault(aec_pkg::aec_req_t r, logic dr);
        case (r.op)
            aec_pkg::AEC_OP_ZERO_BLK: return !dr && (!r.cachable || r.write_through);
            aec_pkg::AEC_OP_CACHE_RD, aec_pkg::AEC_OP_LOAD_RSV, aec_pkg::AEC_OP_STORE_CND,
            aec_pkg::AEC_OP_IFETCH: return r.ea[1:0] != 2'h0;
            aec_pkg::AEC_OP_AUX_LOAD, aec_pkg::AEC_OP_AUX_STORE: return (r.size == aec_pkg::AEC_SZ_HALF) ?
                r.ea[0] : (r.size != aec_pkg::AEC_SZ_BYTE && r.ea[1:0] != 2'h0);
            aec_pkg::AEC_OP_STRING: return r.str_len == 8'h00 || r.str_len > 8'h80;
            default: return 1'b0;
        endcase
    endfunction : exp_fault

    // Expected extra cycles: crossing a word costs two, within a word one
    function automatic logic [1:0] exp_extra(aec_pkg::aec_req_t r);
        logic [2:0] last;
        last = {1'b0, r.ea[1:0]} + ((r.size == aec_pkg::AEC_SZ_WORD) ? 3'h3 : {2'h0, r.size[0]});
        if (r.op > aec_pkg::AEC_OP_INT_STORE) return 2'h0;
        if (last > 3'h3) return 2'h2;
        return {1'b0, r.size == aec_pkg::AEC_SZ_HALF && r.ea[0]};
    endfunction : exp_extra

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test

    task automatic timeout();
        err_total++;
        $display("wrong value at %0t: no answer", $time);
        stop_test();
    endtask : timeout

    task automatic chk_flag(logic got, logic exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic chk_word(logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    // Issue one request, then check the answer and its timing
    task automatic run(aec_pkg::aec_req_t r, logic [31:0] ms);
        logic       f;
        logic [1:0] x;
        int         n;
        f = exp_fault(r, ms[4]);
        x = exp_extra(r);
        @(posedge clock);
        load <= 1'b1;
        next_req <= r;
        machine_state <= ms;
        @(posedge clock);
        load <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (exc_valid !== 1'b1 && acc_valid !== 1'b1 && n < 20);
        if (exc_valid !== 1'b1 && acc_valid !== 1'b1) timeout();
        chk_flag(exc_valid, f);
        chk_flag(acc_valid, !f);
        if (f) chk_word(exc_addr, r.ea);
        else if (r.op != aec_pkg::AEC_OP_STRING) begin
            chk_word(acc_req.ea, r.ea);
            chk_word(acc_req[48:17], r[48:17]);
            chk_word({15'h0, acc_req[16:0]}, {15'h0, r[16:0]});
            chk_word({30'h0, acc_extra_cycles}, {30'h0, x});
            n = 0;
            while (acc_last !== 1'b1 && n < 8) begin
                @(posedge clock);
                #1;
                n++;
            end
            chk_word(n, {30'h0, x});
        end
        n = 0;
        while (req_ready !== 1'b1 && n < 8) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (req_ready !== 1'b1) timeout();
    endtask : run

    // Reset, exhaustive corner table in both endians, then random traffic
    initial begin
        aec_pkg::aec_req_t r;
        void'($urandom(32'hF2B9CCE7));
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        #1;
        chk_flag(req_ready, 1'b1);
        chk_flag(exc_valid | acc_valid | acc_last, 1'b0);
        for (int e = 0; e < 2; e++) begin
            for (int k = 0; k < 8; k++) begin
                r = '{aec_pkg::AEC_OP_ZERO_BLK, aec_pkg::AEC_SZ_WORD, 8'h01, 32'h1F, k[0], k[1], e[0]};
                run(r, {27'h0, k[2], 4'h0});
            end
            for (int o = 0; o < 11; o++) for (int s = 0; s < 4; s++) for (int a = 0; a < 4; a++) begin
                r = '{aec_pkg::aec_op_t'(o), aec_pkg::aec_size_t'(s), 8'h10, 32'h200 + a, 1'b1, 1'b0, e[0]};
                if (!(o < 2 && s == 3)) run(r, $urandom);
            end
            for (int i = 0; i < 4; i++) begin
                r = '{aec_pkg::AEC_OP_STRING, aec_pkg::AEC_SZ_BYTE, 8'h00, 32'h7, 1'b1, 1'b0, e[0]};
                r.str_len = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'h80 : 8'h81;
                run(r, 32'h0);
            end
        end
        repeat (300) begin
            r = '{aec_pkg::aec_op_t'($urandom_range(0, 10)), aec_pkg::aec_size_t'($urandom_range(0, 3)),
                8'($urandom), $urandom, 1'($urandom), 1'($urandom), 1'($urandom)};
            if (r.op < aec_pkg::AEC_OP_STRING) r.size = aec_pkg::aec_size_t'($urandom_range(0, 2));
            run(r, $urandom);
        end
        stop_test();
    end
endmodule : tb
`default_nettype wire
